// >>> eag_core.sv
// eag_core: effective address, branch target, block move step and cycle count
// assumes: sequencer presents one request at a time and reads pointers on the bus
`timescale 1ns/100ps

module eag_core
    import eag_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    output logic req_ready,
    input eag_req_t req,
    output logic ptr_req,
    output logic [23:0] ptr_addr,
    input wire logic ptr_valid,
    input wire logic [23:0] ptr_data,
    output logic res_valid,
    output eag_res_t res
);

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EAG_S_IDLE, EAG_S_PTR, EAG_S_CALC
    } eag_state_t;

    eag_state_t state;
    eag_req_t cur;
    logic [23:0] ptr_q;
    eag_res_t next_res;
    logic needs_ptr;
    logic [15:0] operand16;
    logic [15:0] dp_sum;
    logic [15:0] sp_sum;
    logic [15:0] idx_ptr;

    assign req_ready = (state == EAG_S_IDLE);
    assign ptr_req = (state == EAG_S_PTR);

    always_comb begin
        case (req.mode)
            EAG_M_JMP_IND, EAG_M_JUMP_LONG_IND, EAG_M_DIR_IND, EAG_M_DIR_IND_LONG,
            EAG_M_JMP_IDX_IND, EAG_M_SREL_IND_Y: needs_ptr = 1'b1;
            default: needs_ptr = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= EAG_S_IDLE;
        end else begin
            case (state)
                EAG_S_IDLE: begin
                    if (req_valid) begin
                        state <= needs_ptr ? EAG_S_PTR : EAG_S_CALC;
                    end
                end
                EAG_S_PTR: begin
                    if (ptr_valid) begin
                        state <= EAG_S_CALC;
                    end
                end
                EAG_S_CALC: state <= EAG_S_IDLE;
                default: state <= EAG_S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur <= '0;
        end else if (req_valid && state == EAG_S_IDLE) begin
            cur <= req;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_q <= '0;
        end else if (ptr_valid && state == EAG_S_PTR) begin
            ptr_q <= ptr_data;
        end
    end

    // ------------------------------------------------------------
    // pointer location
    // ------------------------------------------------------------
    logic [15:0] r_op16;
    logic [15:0] r_dp;
    logic [15:0] r_sp;
    logic [15:0] r_ix;
    assign r_op16 = {req.op2, req.op1};
    assign r_dp = req.direct + {8'h00, req.op1};
    assign r_sp = req.sp + {8'h00, req.op1};
    assign r_ix = r_op16 + req.x;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_addr <= '0;
        end else if (req_valid && state == EAG_S_IDLE) begin
            case (req.mode)
                EAG_M_JMP_IND, EAG_M_JUMP_LONG_IND: ptr_addr <= {EAG_BANK_ZERO, r_op16};
                EAG_M_DIR_IND, EAG_M_DIR_IND_LONG: ptr_addr <= {EAG_BANK_ZERO, r_dp};
                EAG_M_JMP_IDX_IND: ptr_addr <= {EAG_BANK_ZERO, r_ix};
                EAG_M_SREL_IND_Y: ptr_addr <= {EAG_BANK_ZERO, r_sp};
                default: ptr_addr <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // result computation
    // ------------------------------------------------------------
    eag_info_t info;
    logic wide;
    logic page_cross;
    logic [15:0] abs_x_sum;

    assign operand16 = {cur.op2, cur.op1};
    assign dp_sum = cur.direct + {8'h00, cur.op1};
    assign sp_sum = cur.sp + {8'h00, cur.op1};
    assign idx_ptr = operand16 + cur.x;
    assign abs_x_sum = operand16 + cur.x;
    assign info = eag_mode_info(cur.mode);
    assign wide = cur.index_op ? ~cur.flag_x : ~cur.flag_m;
    assign page_cross = (abs_x_sum[15:8] != cur.op2);

    always_comb begin
        next_res = '0;
        next_res.pc = cur.pc;
        next_res.program_bank_reg = cur.program_bank_reg;
        next_res.data_bank_reg = cur.data_bank_reg;
        next_res.x = cur.x;
        next_res.y = cur.y;
        next_res.c = cur.c;
        case (cur.mode)
            EAG_M_BRANCH_LONG: begin
                next_res.pc = cur.pc + operand16;
                next_res.load_pc = 1'b1;
            end
            EAG_M_PUSH_REL: begin
                next_res.push_data = cur.pc + operand16;
                next_res.push_en = 1'b1;
                next_res.addr = {EAG_BANK_ZERO, cur.sp};
            end
            EAG_M_JMP_IND, EAG_M_JMP_IDX_IND: begin
                next_res.pc = ptr_q[15:0];
                next_res.load_pc = 1'b1;
            end
            EAG_M_JUMP_LONG_IND: begin
                next_res.pc = ptr_q[15:0];
                next_res.program_bank_reg = ptr_q[23:16];
                next_res.load_pc = 1'b1;
            end
            EAG_M_DIR_IND: next_res.addr = {cur.data_bank_reg, ptr_q[15:0]};
            EAG_M_DIR_IND_LONG: next_res.addr = ptr_q;
            EAG_M_STACK: next_res.addr = {EAG_BANK_ZERO, cur.sp};
            EAG_M_VECTOR: next_res.addr = {EAG_BANK_ZERO, operand16};
            EAG_M_STACK_REL: next_res.addr = {EAG_BANK_ZERO, sp_sum};
            EAG_M_SREL_IND_Y: begin
                next_res.addr = {cur.data_bank_reg, ptr_q[15:0]} + {8'h00, cur.y};
            end
            EAG_M_MOVE_ASC, EAG_M_MOVE_DESC: begin
                next_res.addr = {cur.op1, cur.y};
                next_res.src_addr = {cur.op2, cur.x};
                next_res.data_bank_reg = cur.op1;
                if (cur.mode == EAG_M_MOVE_ASC) begin
                    next_res.x = cur.x + EAG_ONE;
                    next_res.y = cur.y + EAG_ONE;
                end else begin
                    next_res.x = cur.x - EAG_ONE;
                    next_res.y = cur.y - EAG_ONE;
                end
                if (cur.c != 16'h0000) begin
                    next_res.c = cur.c - EAG_ONE;
                end else begin
                    next_res.move_done = 1'b1;
                    next_res.pc = cur.pc + EAG_MOVE_PC_STEP;
                    next_res.load_pc = 1'b1;
                end
            end
            EAG_M_BRANCH: begin
                next_res.pc = cur.pc + {{8{cur.op1[7]}}, cur.op1};
                next_res.load_pc = cur.taken;
            end
            EAG_M_DIRECT: next_res.addr = {EAG_BANK_ZERO, dp_sum};
            EAG_M_ABS_X: next_res.addr = {cur.data_bank_reg, operand16} + {8'h00, cur.x};
            default: next_res.addr = '0;
        endcase
        // cycle and byte counts
        next_res.cycles = info.cycles;
        next_res.bytes = info.bytes;
        if (info.notes[EAG_N_PAGE] && page_cross) begin
            next_res.cycles = next_res.cycles + EAG_CYC_ADD_ONE;
        end
        if (info.notes[EAG_N_TAKEN] && cur.taken) begin
            next_res.cycles = next_res.cycles + EAG_CYC_ADD_ONE;
        end
        if (info.notes[EAG_N_WIDE] && wide) begin
            next_res.cycles = next_res.cycles + EAG_CYC_ADD_ONE;
        end
        if (cur.mode == EAG_M_IMMEDIATE && wide) begin
            next_res.bytes = EAG_LEN_THREE;
        end
        if (info.notes[EAG_N_DL] && cur.direct[7:0] != 8'h00) begin
            next_res.cycles = next_res.cycles + EAG_CYC_ADD_ONE;
        end
        if (info.notes[EAG_N_RMW] && cur.rmw) begin
            next_res.cycles = next_res.cycles + (cur.flag_m ? EAG_CYC_RMW_NARROW
                                                            : EAG_CYC_RMW_WIDE);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            res <= '0;
        end else if (state == EAG_S_CALC) begin
            res <= next_res;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= (state == EAG_S_CALC);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    branch_long_pc_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_BRANCH_LONG |->
            res.load_pc && res.pc == 16'(cur.pc + {cur.op2, cur.op1})
            && res.program_bank_reg == cur.program_bank_reg)
        else $error("long branch target wrong");

    push_rel_flow_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_PUSH_REL |->
            res.push_en && !res.load_pc && res.push_data == 16'(cur.pc + {cur.op2, cur.op1}))
        else $error("push relative result wrong");

    ind_ptr_bank_a: assert property (@(posedge clk) disable iff (!resetn)
        req_valid && req_ready && (req.mode == EAG_M_JMP_IND) |=>
            ptr_req && ptr_addr == {8'h00, $past(req.op2), $past(req.op1)})
        else $error("indirect pointer not in bank zero");

    long_ind_bank_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_JUMP_LONG_IND |->
            res.program_bank_reg == ptr_q[23:16] && res.pc == ptr_q[15:0])
        else $error("long indirect bank not loaded");

    dir_ind_addr_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_DIR_IND |->
            res.addr == {cur.data_bank_reg, ptr_q[15:0]})
        else $error("direct indirect address wrong");

    stack_bank_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && (cur.mode == EAG_M_STACK || cur.mode == EAG_M_VECTOR
            || cur.mode == EAG_M_STACK_REL) |-> res.addr[23:16] == 8'h00)
        else $error("stack access left bank zero");

    move_step_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_MOVE_ASC |->
            res.data_bank_reg == cur.op1 && res.x == 16'(cur.x + 16'h0001)
            && res.src_addr == {cur.op2, cur.x})
        else $error("ascending move step wrong");

    move_done_pc_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && (cur.mode == EAG_M_MOVE_DESC || cur.mode == EAG_M_MOVE_ASC)
            && cur.c == 16'h0000 |-> res.move_done && res.pc == 16'(cur.pc + 16'h0003))
        else $error("move completion pc wrong");

    rmw_cycles_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_DIRECT && cur.rmw && !cur.flag_m
            && cur.direct[7:0] == 8'h00 |-> res.cycles == 5'h07)
        else $error("wide read-modify-write cycles wrong");

    move_cycles_a: assert property (@(posedge clk) disable iff (!resetn)
        req_valid && req_ready && req.mode == EAG_M_MOVE_DESC |->
            ##2 res_valid && res.cycles == 5'h07 && res.bytes == 3'h3)
        else $error("block move timing wrong");

    dir_long_addr_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_DIR_IND_LONG |-> res.addr == ptr_q)
        else $error("direct indirect long address wrong");

    idx_ind_ptr_a: assert property (@(posedge clk) disable iff (!resetn)
        ptr_req && cur.mode == EAG_M_JMP_IDX_IND |-> ptr_addr == {8'h00, idx_ptr})
        else $error("indexed indirect pointer wrong");

    ptr_bank_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        ptr_req |-> ptr_addr[23:16] == 8'h00)
        else $error("pointer left bank zero");

    srel_ind_addr_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_SREL_IND_Y |->
            res.addr == 24'({cur.data_bank_reg, ptr_q[15:0]} + {8'h00, cur.y}))
        else $error("stack relative indirect address wrong");

    move_count_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode inside {EAG_M_MOVE_ASC, EAG_M_MOVE_DESC} && cur.c != 16'h0000
            |-> res.c == 16'(cur.c - 16'h0001) && !res.move_done)
        else $error("move count step wrong");

    branch_taken_cyc_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_BRANCH |-> res.cycles == (cur.taken ? 5'h03 : 5'h02))
        else $error("branch cycles wrong");

    imm_width_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_IMMEDIATE && (cur.index_op ? !cur.flag_x : !cur.flag_m)
            |-> res.bytes == 3'h3 && res.cycles == 5'h03)
        else $error("wide immediate length wrong");

    srel_cycles_a: assert property (@(posedge clk) disable iff (!resetn)
        res_valid && cur.mode == EAG_M_SREL_IND_Y && cur.flag_m && !cur.index_op
            |-> res.cycles == 5'h07 && res.bytes == 3'h2)
        else $error("stack relative indirect timing wrong");

endmodule : eag_core

// >>> eag_pkg.sv
// eag_pkg: constants, modes, request and result carriers of the address generator
// assumes: shared by the generator and the core sequencer that drives it
package eag_pkg;

    localparam int EAG_AW = 24;
    localparam int EAG_DW = 16;
    localparam logic [7:0] EAG_BANK_ZERO = 8'h00;
    localparam logic [15:0] EAG_MOVE_PC_STEP = 16'h0003;
    localparam logic [15:0] EAG_ONE = 16'h0001;

    // base cycles and added cycles
    localparam logic [4:0] EAG_CYC_REL_LONG = 5'h03;
    localparam logic [4:0] EAG_CYC_ABS_IND = 5'h05;
    localparam logic [4:0] EAG_CYC_DIR_IND = 5'h05;
    localparam logic [4:0] EAG_CYC_DIR_IND_LONG = 5'h06;
    localparam logic [4:0] EAG_CYC_ABS_IDX_IND = 5'h06;
    localparam logic [4:0] EAG_CYC_STACK = 5'h03;
    localparam logic [4:0] EAG_CYC_STACK_REL = 5'h04;
    localparam logic [4:0] EAG_CYC_SREL_IND_Y = 5'h07;
    localparam logic [4:0] EAG_CYC_MOVE = 5'h07;
    localparam logic [4:0] EAG_CYC_BRANCH = 5'h02;
    localparam logic [4:0] EAG_CYC_DIRECT = 5'h03;
    localparam logic [4:0] EAG_CYC_ABS_IDX = 5'h04;
    localparam logic [4:0] EAG_CYC_IMM = 5'h02;
    localparam logic [4:0] EAG_CYC_RMW_NARROW = 5'h02;
    localparam logic [4:0] EAG_CYC_RMW_WIDE = 5'h03;
    localparam logic [4:0] EAG_CYC_ADD_ONE = 5'h01;

    // instruction bytes
    localparam logic [2:0] EAG_LEN_ONE = 3'h1;
    localparam logic [2:0] EAG_LEN_TWO = 3'h2;
    localparam logic [2:0] EAG_LEN_THREE = 3'h3;

    // adder selection bits in a mode's info word
    localparam int EAG_N_PAGE = 0;
    localparam int EAG_N_TAKEN = 1;
    localparam int EAG_N_WIDE = 2;
    localparam int EAG_N_DL = 3;
    localparam int EAG_N_RMW = 4;

    typedef enum logic [4:0] {
        EAG_M_BRANCH_LONG, EAG_M_PUSH_REL, EAG_M_JMP_IND, EAG_M_JUMP_LONG_IND,
        EAG_M_DIR_IND, EAG_M_DIR_IND_LONG, EAG_M_JMP_IDX_IND, EAG_M_STACK,
        EAG_M_VECTOR, EAG_M_STACK_REL, EAG_M_SREL_IND_Y, EAG_M_MOVE_ASC,
        EAG_M_MOVE_DESC, EAG_M_BRANCH, EAG_M_DIRECT, EAG_M_ABS_X, EAG_M_IMMEDIATE
    } eag_mode_t;

    typedef struct packed {
        logic [4:0] cycles;
        logic [2:0] bytes;
        logic [4:0] notes;
    } eag_info_t;

    typedef struct packed {
        eag_mode_t mode;
        logic [15:0] pc;
        logic [7:0] program_bank_reg;
        logic [7:0] data_bank_reg;
        logic [15:0] direct;
        logic [15:0] sp;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] c;
        logic [7:0] op1;
        logic [7:0] op2;
        logic flag_m;
        logic flag_x;
        logic index_op;
        logic rmw;
        logic taken;
    } eag_req_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [23:0] src_addr;
        logic [15:0] pc;
        logic load_pc;
        logic [7:0] program_bank_reg;
        logic [7:0] data_bank_reg;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] c;
        logic [15:0] push_data;
        logic push_en;
        logic move_done;
        logic [4:0] cycles;
        logic [2:0] bytes;
    } eag_res_t;

    function automatic eag_info_t eag_mode_info(input eag_mode_t m);
        eag_info_t i;
        i = '{cycles: EAG_CYC_IMM, bytes: EAG_LEN_TWO, notes: 5'h04};
        case (m)
            EAG_M_BRANCH_LONG, EAG_M_PUSH_REL: i = '{EAG_CYC_REL_LONG, EAG_LEN_THREE, 5'h02};
            EAG_M_JMP_IND, EAG_M_JUMP_LONG_IND: i = '{EAG_CYC_ABS_IND, EAG_LEN_THREE, 5'h00};
            EAG_M_DIR_IND: i = '{EAG_CYC_DIR_IND, EAG_LEN_TWO, 5'h0C};
            EAG_M_DIR_IND_LONG: i = '{EAG_CYC_DIR_IND_LONG, EAG_LEN_TWO, 5'h0C};
            EAG_M_JMP_IDX_IND: i = '{EAG_CYC_ABS_IDX_IND, EAG_LEN_THREE, 5'h00};
            EAG_M_STACK, EAG_M_VECTOR: i = '{EAG_CYC_STACK, EAG_LEN_ONE, 5'h00};
            EAG_M_STACK_REL: i = '{EAG_CYC_STACK_REL, EAG_LEN_TWO, 5'h04};
            EAG_M_SREL_IND_Y: i = '{EAG_CYC_SREL_IND_Y, EAG_LEN_TWO, 5'h04};
            EAG_M_MOVE_ASC, EAG_M_MOVE_DESC: i = '{EAG_CYC_MOVE, EAG_LEN_THREE, 5'h00};
            EAG_M_BRANCH: i = '{EAG_CYC_BRANCH, EAG_LEN_TWO, 5'h02};
            EAG_M_DIRECT: i = '{EAG_CYC_DIRECT, EAG_LEN_TWO, 5'h1C};
            EAG_M_ABS_X: i = '{EAG_CYC_ABS_IDX, EAG_LEN_THREE, 5'h15};
            EAG_M_IMMEDIATE: i = '{EAG_CYC_IMM, EAG_LEN_TWO, 5'h04};
            default: i = '{EAG_CYC_IMM, EAG_LEN_TWO, 5'h04};
        endcase
        return i;
    endfunction : eag_mode_info

endpackage : eag_pkg

// >>> eag_ptr_model.sv
// eag_ptr_model: sequencer side that answers pointer reads
// assumes: pointer bytes derived from the address, answer delay set by lat
`timescale 1ns/100ps

module eag_ptr_model
    import eag_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ptr_req,
    input wire logic [23:0] ptr_addr,
    input wire logic [3:0] lat,
    output logic ptr_valid,
    output logic [23:0] ptr_data
);
    // ----------------------------------------
    // pointer answer, idle data inverted
    // ----------------------------------------
    initial begin
        ptr_valid = 1'b0;
        ptr_data = 24'hA5A5A5;
        forever begin
            @(posedge clk);
            #1;
            if (resetn === 1'b1 && ptr_req === 1'b1) begin
                repeat (lat) @(posedge clk);
                #1;
                ptr_valid = 1'b1;
                ptr_data = {ptr_addr[7:0] ^ 8'h3C, ptr_addr[15:0] ^ 16'hC35A};
                @(posedge clk);
                #1;
                ptr_valid = 1'b0;
                ptr_data = ~ptr_data;
            end
        end
    end
endmodule : eag_ptr_model

// >>> eag_core_bench.sv
// eag_core_bench: scenarios for the address generator
// assumes: eag_ptr_model answers pointer reads
`timescale 1ns/100ps

module eag_core_bench
    import eag_pkg::*;
;
    logic clk;
    logic resetn;
    logic req_valid;
    logic req_ready;
    eag_req_t req;
    logic ptr_req;
    logic [23:0] ptr_addr;
    logic ptr_valid;
    logic [23:0] ptr_data;
    logic res_valid;
    eag_res_t res;
    logic [3:0] lat;
    int errors;
    int total_checks;
    eag_req_t r;
    eag_res_t q;
    logic [23:0] pa;

    eag_core i_dut (.clk(clk), .resetn(resetn), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .ptr_req(ptr_req), .ptr_addr(ptr_addr),
        .ptr_valid(ptr_valid), .ptr_data(ptr_data), .res_valid(res_valid), .res(res));
    eag_ptr_model i_ptr (.clk(clk), .resetn(resetn), .ptr_req(ptr_req),
        .ptr_addr(ptr_addr), .lat(lat), .ptr_valid(ptr_valid), .ptr_data(ptr_data));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic summarize();
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    function automatic logic [23:0] pmem(input logic [23:0] a);
        return {a[7:0] ^ 8'h3C, a[15:0] ^ 16'hC35A};
    endfunction : pmem

    task automatic base(input eag_mode_t m);
        r = '0;
        r.mode = m;
        r.flag_m = 1'b1;
        r.flag_x = 1'b1;
        r.data_bank_reg = 8'h5C;
        r.program_bank_reg = 8'h3A;
    endtask : base

    task automatic go();
        int n;
        n = 0;
        pa = 24'hFFFFFF;
        @(posedge clk);
        #1;
        req = r;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        req = ~r;
        while (n < 40) begin
            if (ptr_req === 1'b1) pa = ptr_addr;
            if (res_valid === 1'b1) break;
            @(posedge clk);
            #1;
            n = n + 1;
        end
        q = res;
        if (n >= 40) chk("res_valid", 24'h000001, 24'h000000);
    endtask : go

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_rel_long();
        base(EAG_M_BRANCH_LONG);
        r.pc = 16'hFFF0;
        r.op1 = 8'h20;
        r.taken = 1'b1;
        go();
        chk("pc", 24'h000010, 24'(q.pc));
        chk("load", 24'h000001, 24'(q.load_pc));
        chk("pbank", 24'h00003A, 24'(q.program_bank_reg));
        chk("cyc", 24'h000004, 24'(q.cycles));
        r.mode = EAG_M_PUSH_REL;
        r.op2 = 8'h80;
        go();
        chk("push", 24'h008010, 24'(q.push_data));
        chk("push_en", 24'h000001, 24'(q.push_en));
        chk("load", 24'h000000, 24'(q.load_pc));
    endtask : t_rel_long

    task automatic t_ind();
        logic [23:0] m;
        m = pmem(24'h001234);
        base(EAG_M_JMP_IND);
        r.op1 = 8'h34;
        r.op2 = 8'h12;
        lat = 4'h3;
        go();
        chk("ptr", 24'h001234, pa);
        chk("pc", {8'h00, m[15:0]}, 24'(q.pc));
        chk("pbank", 24'h00003A, 24'(q.program_bank_reg));
        chk("cyc", 24'h000005, 24'(q.cycles));
        r.mode = EAG_M_JUMP_LONG_IND;
        go();
        chk("pbank", {16'h0000, m[23:16]}, 24'(q.program_bank_reg));
        chk("pc", {8'h00, m[15:0]}, 24'(q.pc));
        lat = 4'h0;
    endtask : t_ind

    task automatic t_dir();
        logic [23:0] m;
        m = pmem(24'h000182);
        base(EAG_M_DIR_IND);
        r.direct = 16'h0102;
        r.op1 = 8'h80;
        go();
        chk("ptr", 24'h000182, pa);
        chk("addr", {8'h5C, m[15:0]}, q.addr);
        chk("cyc", 24'h000006, 24'(q.cycles));
        r.mode = EAG_M_DIR_IND_LONG;
        go();
        chk("addr", m, q.addr);
        chk("cyc", 24'h000007, 24'(q.cycles));
        r.mode = EAG_M_DIR_IND;
        r.direct = 16'h0100;
        go();
        chk("cyc", 24'h000005, 24'(q.cycles));
    endtask : t_dir

    task automatic t_idx_ind();
        logic [23:0] m;
        m = pmem(24'h000010);
        base(EAG_M_JMP_IDX_IND);
        r.op1 = 8'hF0;
        r.op2 = 8'hFF;
        r.x = 16'h0020;
        go();
        chk("ptr", 24'h000010, pa);
        chk("pc", {8'h00, m[15:0]}, 24'(q.pc));
        chk("pbank", 24'h00003A, 24'(q.program_bank_reg));
        chk("cyc", 24'h000006, 24'(q.cycles));
    endtask : t_idx_ind

    task automatic t_stack();
        base(EAG_M_STACK);
        r.sp = 16'h01FF;
        go();
        chk("addr", 24'h0001FF, q.addr);
        base(EAG_M_VECTOR);
        r.op1 = 8'hFE;
        r.op2 = 8'hFF;
        go();
        chk("addr", 24'h00FFFE, q.addr);
        base(EAG_M_STACK_REL);
        r.sp = 16'hFFF0;
        r.op1 = 8'hFF;
        go();
        chk("addr", 24'h0000EF, q.addr);
        chk("cyc", 24'h000004, 24'(q.cycles));
        chk("len", 24'h000002, 24'(q.bytes));
        r.flag_m = 1'b0;
        go();
        chk("cyc", 24'h000005, 24'(q.cycles));
    endtask : t_stack

    task automatic t_srel_y();
        logic [23:0] m;
        m = pmem(24'h000110);
        base(EAG_M_SREL_IND_Y);
        r.sp = 16'h0100;
        r.op1 = 8'h10;
        r.y = 16'h4000;
        go();
        chk("ptr", 24'h000110, pa);
        chk("addr", {8'h5C, m[15:0]} + 24'h004000, q.addr);
        chk("cyc", 24'h000007, 24'(q.cycles));
        chk("len", 24'h000002, 24'(q.bytes));
    endtask : t_srel_y

    task automatic t_move();
        base(EAG_M_MOVE_ASC);
        r.op1 = 8'h7E;
        r.op2 = 8'h01;
        r.x = 16'hFFFF;
        r.y = 16'h1000;
        r.c = 16'h0001;
        r.pc = 16'h2000;
        go();
        chk("dst", 24'h7E1000, q.addr);
        chk("src", 24'h01FFFF, q.src_addr);
        chk("dbank", 24'h00007E, 24'(q.data_bank_reg));
        chk("x", 24'h000000, 24'(q.x));
        chk("y", 24'h001001, 24'(q.y));
        chk("c", 24'h000000, 24'(q.c));
        chk("done", 24'h000000, 24'(q.move_done));
        chk("cyc", 24'h000007, 24'(q.cycles));
        chk("len", 24'h000003, 24'(q.bytes));
        r.x = 16'h0000;
        r.y = 16'h1001;
        r.c = 16'h0000;
        go();
        chk("done", 24'h000001, 24'(q.move_done));
        chk("pc", 24'h002003, 24'(q.pc));
        chk("c", 24'h000000, 24'(q.c));
        r.mode = EAG_M_MOVE_DESC;
        r.y = 16'h0000;
        r.c = 16'h0005;
        go();
        chk("x", 24'h00FFFF, 24'(q.x));
        chk("y", 24'h00FFFF, 24'(q.y));
        chk("c", 24'h000004, 24'(q.c));
    endtask : t_move

    task automatic t_cycles();
        base(EAG_M_BRANCH);
        go();
        chk("cyc", 24'h000002, 24'(q.cycles));
        r.taken = 1'b1;
        go();
        chk("cyc", 24'h000003, 24'(q.cycles));
        base(EAG_M_ABS_X);
        r.op1 = 8'hF0;
        r.op2 = 8'h10;
        r.x = 16'h0020;
        go();
        chk("cyc", 24'h000005, 24'(q.cycles));
        chk("addr", 24'h5C1110, q.addr);
        r.x = 16'h0008;
        go();
        chk("cyc", 24'h000004, 24'(q.cycles));
        base(EAG_M_DIRECT);
        r.rmw = 1'b1;
        go();
        chk("cyc", 24'h000005, 24'(q.cycles));
        r.flag_m = 1'b0;
        go();
        chk("cyc", 24'h000007, 24'(q.cycles));
        r.direct = 16'h0001;
        go();
        chk("cyc", 24'h000008, 24'(q.cycles));
        base(EAG_M_IMMEDIATE);
        go();
        chk("len", 24'h000002, 24'(q.bytes));
        chk("cyc", 24'h000002, 24'(q.cycles));
        r.index_op = 1'b1;
        r.flag_x = 1'b0;
        go();
        chk("len", 24'h000003, 24'(q.bytes));
        chk("cyc", 24'h000003, 24'(q.cycles));
    endtask : t_cycles

    // ----------------------------------------
    // sequence and watchdog
    // ----------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        resetn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        lat = 4'h0;
        pa = 24'h000000;
        repeat (20) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_rel_long();
        t_ind();
        t_dir();
        t_idx_ind();
        t_stack();
        t_srel_y();
        t_move();
        t_cycles();
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clk);
        errors = errors + 1;
        summarize();
    end
endmodule : eag_core_bench
